// file: logic/scb_pkg.sv
// package for the setup configuration bank: register map, field layout, reset values
// assumes a simple word-addressed register port supplied by the serial front end
package scb_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int          SCB_NUM_SETUPS     = 8;
	localparam logic [7:0]  SCB_ADDR_REF_GAIN  = 8'h19;
	localparam logic [7:0]  SCB_ADDR_FILTER    = 8'h21;
	localparam logic [7:0]  SCB_ADDR_ZERO_CORR = 8'h29;
	localparam logic [15:0] SCB_REF_GAIN_RST   = 16'h0000;
	localparam logic [23:0] SCB_FILTER_RST     = 24'h002030;
	localparam logic [15:0] SCB_ZERO_CORR_RST  = 16'h8000;
	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int          SCB_BYPASS_BIT     = 0;
	localparam int          SCB_GAIN_LSB       = 1;
	localparam int          SCB_REFSEL_LSB     = 4;
	localparam int          SCB_NEGBUF_BIT     = 6;
	localparam int          SCB_FTYPE_LSB      = 12;
	localparam int          SCB_RATE_LSB       = 0;
	localparam logic [23:0] SCB_FILTER_WMASK   = 24'h00f7ff;
	localparam logic [15:0] SCB_REF_GAIN_WMASK = 16'h007f;
	localparam logic [3:0]  SCB_FTYPE_LAST     = 4'h8;
	localparam logic [10:0] SCB_RATE_MIN       = 11'h001;
	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SCB_REF_EXT_ONE  = 2'h0,
		SCB_REF_EXT_TWO  = 2'h1,
		SCB_REF_INTERNAL = 2'h2,
		SCB_REF_SUPPLY   = 2'h3
	} scb_ref_e;
	typedef enum logic [3:0] {
		SCB_FLT_SINC4      = 4'h0,
		SCB_FLT_SINC4_AVG  = 4'h1,
		SCB_FLT_SINC3      = 4'h2,
		SCB_FLT_SINC3_REJ  = 4'h3,
		SCB_FLT_SINC3_AVG  = 4'h4,
		SCB_FLT_POST1      = 4'h5,
		SCB_FLT_POST2      = 4'h6,
		SCB_FLT_POST3      = 4'h7,
		SCB_FLT_POST4      = 4'h8
	} scb_flt_e;
endpackage

// file: logic/scb_setup_if.sv
// bundle carrying the decoded setup selected by the active channel
// assumes one clock domain; the bank drives the raw words, the decoder reads them and drives the decoded controls
`timescale 1ns/100ps
interface scb_setup_if;
	logic [15:0] refGain;
	logic [23:0] filter;
	logic [1:0]  refSel;
	logic        negBufOn;
	logic [7:0]  gainFactor;
	logic [3:0]  filterType;
	logic        sixtyHzNotch;
	logic        postFilter;
	logic        typeValid;
	logic [10:0] rateWord;
	modport bank (output refGain, output filter, input refSel, input negBufOn,
		input gainFactor, input filterType, input sixtyHzNotch, input postFilter,
		input typeValid, input rateWord);
	modport dec (input refGain, input filter, output refSel, output negBufOn,
		output gainFactor, output filterType, output sixtyHzNotch, output postFilter,
		output typeValid, output rateWord);
endinterface

// file: logic/scb_setup_decode.sv
// decodes one raw setup (reference/gain word and filter word) into controls
// assumes the words are already register outputs on the same clock
`timescale 1ns/100ps
module scb_setup_decode
	import scb_pkg::*;
(
	scb_setup_if.dec sIf
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// all outputs follow register words directly, no extra latency
	always_comb begin
		sIf.refSel       = sIf.refGain[SCB_REFSEL_LSB +: 2];
		sIf.negBufOn     = sIf.refGain[SCB_NEGBUF_BIT];
		// bypass forces unity gain whatever the gain code says
		if (sIf.refGain[SCB_BYPASS_BIT]) begin
			sIf.gainFactor = 8'h01;
		end else begin
			sIf.gainFactor = 8'h01 << sIf.refGain[SCB_GAIN_LSB +: 3];
		end
		sIf.filterType   = sIf.filter[SCB_FTYPE_LSB +: 4];
		sIf.sixtyHzNotch = (sIf.filterType == SCB_FLT_SINC3_REJ);
		sIf.postFilter   = (sIf.filterType >= SCB_FLT_POST1) &&
			(sIf.filterType <= SCB_FTYPE_LAST);
		sIf.typeValid    = (sIf.filterType <= SCB_FTYPE_LAST);
		// a zero rate word runs as one
		if (sIf.filter[SCB_RATE_LSB +: 11] == 11'h000) begin
			sIf.rateWord = SCB_RATE_MIN;
		end else begin
			sIf.rateWord = sIf.filter[SCB_RATE_LSB +: 11];
		end
	end
endmodule // scb_setup_decode

// file: logic/scb_config_bank.sv
// eight-copy setup configuration bank with calibration write-back
// assumes a single-cycle register port driven by the serial front end on clk
`timescale 1ns/100ps
module scb_config_bank
	import scb_pkg::*;
#(
	parameter int NSETUP = SCB_NUM_SETUPS
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWr,
	input  wire logic        regRd,
	input  wire logic [23:0] regWdata,
	output logic [23:0]      regRdata,
	output logic             regHit,
	input  wire logic [2:0]  activeSetup,
	input  wire logic        calDone,
	input  wire logic [15:0] calResult,
	output logic [1:0]       refSel,
	output logic             negBufOn,
	output logic [7:0]       gainFactor,
	output logic [3:0]       filterType,
	output logic             sixtyHzNotch,
	output logic             postFilter,
	output logic             typeValid,
	output logic [10:0]      rateWord,
	output logic [15:0]      zeroCorr
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [15:0] refGain_r  [NSETUP];
	logic [15:0] refGain_nxt[NSETUP];
	logic [23:0] filter_r   [NSETUP];
	logic [23:0] filter_nxt [NSETUP];
	logic [15:0] zero_r     [NSETUP];
	logic [15:0] zero_nxt   [NSETUP];
	logic [23:0] rdata_r;
	logic [23:0] rdata_nxt;
	logic        hit_r;
	logic        hit_nxt;

	// returns 1 when addr falls within base..base+NSETUP-1
	function automatic logic inBank(input logic [7:0] addr, input logic [7:0] base);
		inBank = (addr >= base) && (addr < base + 8'(NSETUP));
	endfunction

	// index of a register inside its bank
	function automatic logic [2:0] bankIdx(input logic [7:0] addr, input logic [7:0] base);
		logic [7:0] d;
		d = addr - base;
		bankIdx = d[2:0];
	endfunction

	// ------------------------------------------------------------
	// write path and calibration write-back
	// ------------------------------------------------------------
	// calibration wins over a host write to the same word in the same cycle,
	// since the host is told not to touch it during calibration anyway
	always_comb begin
		for (int i = 0; i < NSETUP; i++) begin
			refGain_nxt[i] = refGain_r[i];
			filter_nxt[i]  = filter_r[i];
			zero_nxt[i]    = zero_r[i];
		end
		if (regWr && inBank(regAddr, SCB_ADDR_REF_GAIN)) begin
			refGain_nxt[bankIdx(regAddr, SCB_ADDR_REF_GAIN)] =
				regWdata[15:0] & SCB_REF_GAIN_WMASK;
		end
		if (regWr && inBank(regAddr, SCB_ADDR_FILTER)) begin
			filter_nxt[bankIdx(regAddr, SCB_ADDR_FILTER)] =
				regWdata & SCB_FILTER_WMASK;
		end
		if (regWr && inBank(regAddr, SCB_ADDR_ZERO_CORR)) begin
			zero_nxt[bankIdx(regAddr, SCB_ADDR_ZERO_CORR)] = regWdata[15:0];
		end
		// single active channel makes activeSetup unambiguous
		if (calDone) begin
			zero_nxt[activeSetup] = calResult;
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < NSETUP; i++) begin
			if (rst) begin
				refGain_r[i] <= SCB_REF_GAIN_RST;
				filter_r[i]  <= SCB_FILTER_RST;
				zero_r[i]    <= SCB_ZERO_CORR_RST;
			end else begin
				refGain_r[i] <= refGain_nxt[i];
				filter_r[i]  <= filter_nxt[i];
				zero_r[i]    <= zero_nxt[i];
			end
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// data appears one cycle after regRd; unmapped addresses read zero, hit low
	always_comb begin
		rdata_nxt = rdata_r;
		hit_nxt   = 1'b0;
		if (regRd) begin
			rdata_nxt = 24'h000000;
			if (inBank(regAddr, SCB_ADDR_REF_GAIN)) begin
				rdata_nxt = {8'h00, refGain_r[bankIdx(regAddr, SCB_ADDR_REF_GAIN)]};
				hit_nxt   = 1'b1;
			end else if (inBank(regAddr, SCB_ADDR_FILTER)) begin
				rdata_nxt = filter_r[bankIdx(regAddr, SCB_ADDR_FILTER)];
				hit_nxt   = 1'b1;
			end else if (inBank(regAddr, SCB_ADDR_ZERO_CORR)) begin
				rdata_nxt = {8'h00, zero_r[bankIdx(regAddr, SCB_ADDR_ZERO_CORR)]};
				hit_nxt   = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r <= 24'h000000;
			hit_r   <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			hit_r   <= hit_nxt;
		end
	end

	assign regRdata = rdata_r;
	assign regHit   = hit_r;

	// ------------------------------------------------------------
	// active setup decode
	// ------------------------------------------------------------
	scb_setup_if sIf ();

	// raw words of the setup the active channel points at
	assign sIf.refGain = refGain_r[activeSetup];
	assign sIf.filter  = filter_r[activeSetup];

	scb_setup_decode u_dec (
		.sIf (sIf.dec)
	);

	assign refSel       = sIf.refSel;
	assign negBufOn     = sIf.negBufOn;
	assign gainFactor   = sIf.gainFactor;
	assign filterType   = sIf.filterType;
	assign sixtyHzNotch = sIf.sixtyHzNotch;
	assign postFilter   = sIf.postFilter;
	assign typeValid    = sIf.typeValid;
	assign rateWord     = sIf.rateWord;
	assign zeroCorr     = zero_r[activeSetup];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_calPulse;
		calDone ##1 1'b1;
	endsequence

	a_cal_writeback: assert property (@(posedge clk) disable iff (rst)
		calDone |=> zero_r[$past(activeSetup)] == $past(calResult))
		else $error("calibration result not stored");

	a_cal_readback: assert property (@(posedge clk) disable iff (rst)
		s_calPulse ##0 (regRd && regAddr == SCB_ADDR_ZERO_CORR + 8'($past(activeSetup))
			&& !calDone) |=> regRdata[15:0] == $past(calResult, 2))
		else $error("correction readback mismatch");

	a_filter_reserved: assert property (@(posedge clk) disable iff (rst)
		regRd && inBank(regAddr, SCB_ADDR_FILTER) |=> regRdata[23:16] == 8'h00
			&& regRdata[11] == 1'b0)
		else $error("reserved filter bits not zero");

	a_rate_zero: assert property (@(posedge clk) disable iff (rst)
		sIf.filter[10:0] == 11'h000 |-> rateWord == 11'h001)
		else $error("zero rate word not treated as one");

	a_bypass_gain: assert property (@(posedge clk) disable iff (rst)
		sIf.refGain[SCB_BYPASS_BIT] |-> gainFactor == 8'h01)
		else $error("bypass did not force unity gain");

	a_gain_max: assert property (@(posedge clk) disable iff (rst)
		sIf.refGain[3:0] == 4'he |-> gainFactor == 8'h80)
		else $error("gain code 7 not 128");

	a_reset_filter: assert property (@(posedge clk)
		$past(rst) |-> filter_r[activeSetup] == 24'h002030
			&& zero_r[activeSetup] == 16'h8000 && refGain_r[activeSetup] == 16'h0000)
		else $error("reset values wrong");

	a_notch_mode: assert property (@(posedge clk) disable iff (rst)
		sixtyHzNotch |-> filterType == 4'h3 && !postFilter)
		else $error("notch flag wrong");

	a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
		regRd && (regAddr < 8'h19 || regAddr > 8'h30) |=> !regHit && regRdata == 24'h0)
		else $error("unmapped read answered");

	a_ref_select: assert property (@(posedge clk) disable iff (rst)
		refSel == sIf.refGain[5:4] && negBufOn == sIf.refGain[6])
		else $error("reference controls wrong");

	// host accesses, one step each; reads compare with the word held at the
	// request edge, since a write landing on that same edge shows up later
	sequence s_filterWrite;
		regWr && inBank(regAddr, SCB_ADDR_FILTER);
	endsequence

	sequence s_refGainWrite;
		regWr && inBank(regAddr, SCB_ADDR_REF_GAIN);
	endsequence

	sequence s_zeroWrite;
		regWr && inBank(regAddr, SCB_ADDR_ZERO_CORR) && !calDone;
	endsequence

	sequence s_filterRead;
		regRd && inBank(regAddr, SCB_ADDR_FILTER);
	endsequence

	sequence s_refGainRead;
		regRd && inBank(regAddr, SCB_ADDR_REF_GAIN);
	endsequence

	sequence s_zeroRead;
		regRd && inBank(regAddr, SCB_ADDR_ZERO_CORR);
	endsequence

	a_filter_write: assert property (@(posedge clk) disable iff (rst)
		s_filterWrite |=> filter_r[3'($past(regAddr) - SCB_ADDR_FILTER)]
			== ($past(regWdata) & SCB_FILTER_WMASK))
		else $error("filter write not stored");

	a_refgain_write: assert property (@(posedge clk) disable iff (rst)
		s_refGainWrite |=> refGain_r[3'($past(regAddr) - SCB_ADDR_REF_GAIN)]
			== ($past(regWdata[15:0]) & SCB_REF_GAIN_WMASK))
		else $error("reference and gain write not stored");

	a_zero_write: assert property (@(posedge clk) disable iff (rst)
		s_zeroWrite |=> zero_r[3'($past(regAddr) - SCB_ADDR_ZERO_CORR)]
			== $past(regWdata[15:0]))
		else $error("correction write not stored");

	a_filter_read: assert property (@(posedge clk) disable iff (rst)
		s_filterRead |=> regHit
			&& regRdata == $past(filter_r[3'(regAddr - SCB_ADDR_FILTER)]))
		else $error("filter readback wrong");

	a_refgain_read: assert property (@(posedge clk) disable iff (rst)
		s_refGainRead |=> regHit
			&& regRdata == {8'h00, $past(refGain_r[3'(regAddr - SCB_ADDR_REF_GAIN)])})
		else $error("reference and gain readback wrong");

	a_zero_read: assert property (@(posedge clk) disable iff (rst)
		s_zeroRead |=> regHit
			&& regRdata == {8'h00, $past(zero_r[3'(regAddr - SCB_ADDR_ZERO_CORR)])})
		else $error("correction readback wrong");

	a_filter_hold: assert property (@(posedge clk) disable iff (rst)
		!regWr |=> filter_r[$past(activeSetup)] == $past(filter_r[activeSetup]))
		else $error("idle filter setup changed");

	a_zero_hold: assert property (@(posedge clk) disable iff (rst)
		!regWr && !calDone
			|=> zero_r[$past(activeSetup)] == $past(zero_r[activeSetup]))
		else $error("idle correction word changed");

	a_cal_priority: assert property (@(posedge clk) disable iff (rst)
		calDone && regWr && regAddr == SCB_ADDR_ZERO_CORR + 8'(activeSetup)
			|=> zero_r[$past(activeSetup)] == $past(calResult))
		else $error("host write beat calibration");

	a_reserved_type: assert property (@(posedge clk) disable iff (rst)
		sIf.filter[15:12] > SCB_FTYPE_LAST
			|-> !typeValid && !postFilter && !sixtyHzNotch)
		else $error("reserved filter code decoded");

	a_post_range: assert property (@(posedge clk) disable iff (rst)
		postFilter |-> typeValid && filterType >= 4'h5 && filterType <= 4'h8)
		else $error("post filter flag wrong");

	a_gain_unity: assert property (@(posedge clk) disable iff (rst)
		sIf.refGain[3:0] == 4'h0 |-> gainFactor == 8'h01)
		else $error("gain code 0 not unity");

	a_rate_pass: assert property (@(posedge clk) disable iff (rst)
		sIf.filter[10:0] != 11'h000 |-> rateWord == sIf.filter[10:0])
		else $error("rate word altered");

	a_hit_after_read: assert property (@(posedge clk) disable iff (rst)
		regHit |-> $past(regRd))
		else $error("hit without a read");

	a_reset_clears: assert property (@(posedge clk)
		$past(rst) && !rst |-> !regHit && regRdata == 24'h000000 && zeroCorr == SCB_ZERO_CORR_RST)
		else $error("read port or correction not cleared by reset");
endmodule // scb_config_bank

// file: verification/scb_config_bank_tb_top.sv
// testbench for the setup configuration bank: array model compared at every result
// assumes one-cycle strobes and registered read data one cycle after the read edge
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin nCompared++; if ((gt) !== (ex)) begin errors++; \
	$display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module scb_config_bank_tb_top
	import scb_pkg::*;
;
	// ------------------------------------------------------------
	// stimulus and model state
	// ------------------------------------------------------------
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  regAddr = 8'h00;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [23:0] regWdata = 24'h000000;
	logic [2:0]  activeSetup = 3'h0;
	logic        calDone = 1'b0;
	logic [15:0] calResult = 16'h0000;
	logic [23:0] regRdata;
	logic        regHit;
	logic [1:0]  refSel;
	logic        negBufOn;
	logic [7:0]  gainFactor;
	logic [3:0]  filterType;
	logic        sixtyHzNotch;
	logic        postFilter;
	logic        typeValid;
	logic [10:0] rateWord;
	logic [15:0] zeroCorr;
	logic [15:0] mRg [8];
	logic [23:0] mFlt [8];
	logic [15:0] mZc [8];
	logic [23:0] r;
	integer      seed = 32'h414c;
	int          errors = 0;
	int          nCompared = 0;
	int          cycles = 0;

	scb_config_bank #(.NSETUP(8)) dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWr(regWr),
		.regRd(regRd), .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit),
		.activeSetup(activeSetup), .calDone(calDone), .calResult(calResult), .refSel(refSel),
		.negBufOn(negBufOn), .gainFactor(gainFactor), .filterType(filterType),
		.sixtyHzNotch(sixtyHzNotch), .postFilter(postFilter), .typeValid(typeValid),
		.rateWord(rateWord), .zeroCorr(zeroCorr));

	// clock and a hang guard; 20000 cycles is about ten times the expected run
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic modelReset();
		for (int s = 0; s < 8; s++) begin
			mRg[s] = 16'h0000;
			mFlt[s] = 24'h002030;
			mZc[s] = 16'h8000;
		end
	endtask

	// one write; model keeps only the bits the bank stores
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		if (a >= 8'h19 && a <= 8'h20) mRg[3'(a - 8'h19)] = d[15:0] & 16'h007f;
		else if (a >= 8'h21 && a <= 8'h28) mFlt[3'(a - 8'h21)] = d & 24'h00f7ff;
		else if (a >= 8'h29 && a <= 8'h30) mZc[3'(a - 8'h29)] = d[15:0];
	endtask

	task automatic rd(input logic [7:0] a);
		logic [23:0] ex;
		logic        hit;
		hit = (a >= 8'h19 && a <= 8'h30);
		ex = 24'h000000;
		if (hit && a <= 8'h20) ex = {8'h00, mRg[3'(a - 8'h19)]};
		else if (hit && a <= 8'h28) ex = mFlt[3'(a - 8'h21)];
		else if (hit) ex = {8'h00, mZc[3'(a - 8'h29)]};
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		`CHK("regRdata", ex, regRdata)
		`CHK("regHit", hit, regHit)
	endtask

	task automatic rdAll();
		for (int a = 8'h17; a <= 8'h32; a++) rd(8'(a));
	endtask

	// decoded controls of one setup, selected as the active channel would
	task automatic chkDec(input logic [2:0] s);
		logic [3:0]  ft;
		logic [10:0] rw;
		@(posedge clk);
		activeSetup <= s;
		@(posedge clk);
		#1;
		ft = mFlt[s][15:12];
		rw = mFlt[s][10:0];
		`CHK("refSel", mRg[s][5:4], refSel)
		`CHK("negBufOn", mRg[s][6], negBufOn)
		`CHK("gainFactor", mRg[s][0] ? 8'h01 : 8'h01 << mRg[s][3:1], gainFactor)
		`CHK("filterType", ft, filterType)
		`CHK("sixtyHzNotch", ft == 4'h3, sixtyHzNotch)
		`CHK("postFilter", ft >= 4'h5 && ft <= 4'h8, postFilter)
		`CHK("typeValid", ft <= 4'h8, typeValid)
		`CHK("rateWord", rw == 11'h000 ? 11'h001 : rw, rateWord)
		`CHK("zeroCorr", mZc[s], zeroCorr)
	endtask

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", nCompared, errors);
		if (errors == 0 && nCompared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		modelReset();
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rdAll();
		for (int s = 0; s < 8; s++) chkDec(3'(s));
		$display("test reset values done");
		// every bypass/gain and filter-type code in every setup; random reserved bits must drop
		for (int s = 0; s < 8; s++) begin
			for (int k = 0; k < 16; k++) begin
				r = 24'($random(seed));
				wr(8'h19 + 8'(s), {r[23:4], 4'(k)});
				r = 24'($random(seed));
				wr(8'h21 + 8'(s), {r[23:16], 4'(k), r[11], (k == 2) ? 11'h000 : r[10:0]});
				wr(8'h29 + 8'(s), 24'($random(seed)));
				chkDec(3'(s));
				rd(8'h19 + 8'(s));
				rd(8'h21 + 8'(s));
			end
		end
		$display("test field decode done");
		// calibration write-back; odd setups also see a host write in the same cycle
		for (int s = 0; s < 8; s++) begin
			r = 24'($random(seed));
			@(posedge clk);
			activeSetup <= 3'(s);
			calDone <= 1'b1;
			calResult <= r[15:0];
			regAddr <= 8'h29 + 8'(s);
			regWdata <= ~r;
			regWr <= s[0];
			@(posedge clk);
			calDone <= 1'b0;
			regWr <= 1'b0;
			regRd <= 1'b1;
			mZc[s] = r[15:0];
			@(posedge clk);
			regRd <= 1'b0;
			#1;
			`CHK("calReadback", {8'h00, mZc[s]}, regRdata)
			rd(8'h29 + 8'(s));
			chkDec(3'(s));
		end
		$display("test calibration done");
		// unmapped writes change nothing, then a reset in mid-run restores defaults
		wr(8'h00, 24'hffffff);
		wr(8'h31, 24'hffffff);
		wr(8'hff, 24'hffffff);
		rdAll();
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		modelReset();
		rdAll();
		chkDec(3'h7);
		$display("test unmapped and second reset done");
		tally_and_finish();
	end
endmodule // scb_config_bank_tb_top
